/* usb_ep_pkg.sv */
package usb_ep_pkg;

   // register byte offsets on the avalon slave
   localparam logic [5:0] off_rx_csr = 6'h00;
   localparam logic [5:0] off_rx_type = 6'h04;
   localparam logic [5:0] off_rx_interval = 6'h08;
   localparam logic [5:0] off_rx_limit = 6'h0c;
   localparam logic [5:0] off_rx_addr = 6'h10;
   localparam logic [5:0] off_rx_sizing = 6'h14;
   localparam logic [5:0] off_tx_csr = 6'h18;
   localparam logic [5:0] off_tx_type = 6'h1c;
   localparam logic [5:0] off_tx_interval = 6'h20;
   localparam logic [5:0] off_tx_limit = 6'h24;
   localparam logic [5:0] off_tx_addr = 6'h28;
   localparam logic [5:0] off_tx_sizing = 6'h2c;
   localparam logic [5:0] off_auto_in = 6'h30;

   // receive control/status bit positions
   localparam int rx_ready_bit = 0;
   localparam int rx_err_bit = 2;
   localparam int rx_nak_bit = 3;
   localparam int rx_discard_bit = 4;
   localparam int rx_req_bit = 5;
   localparam int rx_stall_bit = 6;
   localparam int rx_tog_reset_bit = 7;
   localparam int rx_tog_bit = 9;
   localparam int rx_tog_we_bit = 10;
   localparam int rx_style_bit = 11;
   localparam int rx_nyet_bit = 12;
   localparam int rx_dma_bit = 13;

   // transmit control/status bit positions
   localparam int tx_ready_bit = 0;
   localparam int tx_occ_bit = 1;
   localparam int tx_err_bit = 2;
   localparam int tx_discard_bit = 3;
   localparam int tx_stall_bit = 5;
   localparam int tx_tog_reset_bit = 6;
   localparam int tx_nak_bit = 7;
   localparam int tx_tog_bit = 8;
   localparam int tx_tog_we_bit = 9;
   localparam int tx_style_bit = 10;
   localparam int tx_force_bit = 11;
   localparam int tx_dma_bit = 12;
   localparam int tx_dir_bit = 13;

   // endpoint type fields and sizing
   localparam int speed_lsb = 6;
   localparam int type_lsb = 4;
   localparam int dbuf_bit = 4;
   localparam logic [1:0] tt_bulk = 2'h2;
   localparam logic [1:0] tt_interrupt = 2'h3;
   localparam logic [1:0] auto_in_a = 2'h1;
   localparam logic [1:0] auto_in_b = 2'h3;
   localparam logic [1:0] last_try = 2'h2;
   localparam logic [7:0] frames_max = 8'hff;

   // link handshakes
   typedef enum logic [2:0] {resp_ack, resp_nak, resp_stall, resp_data, resp_nyet, resp_none} link_resp_e;

   // token request to the link
   typedef struct packed {
      logic is_out;
      logic [6:0] target_address;
      logic [3:0] remote_endpoint;
      logic [1:0] speed;
      logic [1:0] transfer_type;
      logic toggle_value;
   } token_s;

   // answer from the link
   typedef struct packed {
      link_resp_e kind;
      logic toggle_value;
   } link_resp_s;

endpackage : usb_ep_pkg

/* usb_host_bulk_interrupt_endpoint.sv */
// Behaviour
// - double_buffer_enable lets each endpoint buffer hold two packets instead of one.
// - receive dma request while a packet waits; completion event suppressed, errors still signalled.
// - auto_in_field 01 or 11 with dma: clearing receive_packet_ready sets in_request.
// - tokens carry programmed address, remote endpoint, speed and transfer_type; bulk is 10.
// - bulk interval holds nak limit in frames; zero means retry forever.
// - receive control has dma enable 13, nyet_disable 12, dma_request_style 11 kept zero.
// - receive toggle tracked, written via bit 9 with enable bit 10, reset by bit 7.
// - receive discard_buffer drops one packet; twice needed when double buffered.
// - setting in_request sends an in token and waits for data.
// - good data sets receive_packet_ready bit 0; stall sets stall_seen bit 6.
// - in nak retried until success or limit; limit sets nak timeout flag.
// - no response: two more attempts, then error bit 2 in either direction.
// - clearing receive nak flag resumes; clear in_request first to abort.
// - transmit dma request while space; with style set only errors signal events.
// - transmit control: direction 13, dma enable 12, forced_toggle 11, style 10.
// - transmit toggle tracked, written via bit 8 with enable bit 9, reset by bit 6.
// - tx_buffer_occupied at bit 1; discard_buffer bit 3 drops one packet.
// - transmit_packet_ready sends out token plus data; an ack that empties the buffer clears bit 0.
// - transmit stall sets bit 5; naks retried until limit sets bit 7.
// - clearing transmit nak flag resumes; flush first to abort.
// - interrupt type behaves as bulk but interval is the polling interval.
// - receive nak timeout indication sits at bit 3.
`timescale 1ns/1ps
module usb_host_bulk_interrupt_endpoint (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // avalon-mm slave
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // link token request and answer
   output logic token_valid,
   input wire logic token_ready,
   output usb_ep_pkg::token_s token,
   input wire logic resp_valid,
   input wire usb_ep_pkg::link_resp_s resp,
   // frame tick, one pulse per frame or microframe
   input wire logic frame_tick,
   // transmit buffer loader marks a whole packet written
   input wire logic tx_load_done,
   // dma requests and endpoint events
   output logic rx_dma_req,
   output logic tx_dma_req,
   output logic rx_ep_event,
   output logic tx_ep_event
);
   typedef enum {st_idle, st_token, st_wait} eng_e;
   // configuration storage
   logic [7:0] rx_type_reg, tx_type_reg, rx_interval_reg, tx_interval_reg;
   logic [10:0] rx_limit_reg, tx_limit_reg;
   logic [6:0] rx_addr_reg, tx_addr_reg;
   logic rx_dbuf_reg, tx_dbuf_reg;
   logic [1:0] auto_in_reg;
   // receive state
   logic [1:0] rx_count_reg, rx_count_next, rx_tries_reg;
   logic rx_req_reg, rx_err_reg, rx_nak_reg, rx_stall_reg, rx_tog_reg;
   logic rx_dma_reg, rx_nyet_reg, rx_style_reg;
   logic [7:0] rx_frames_reg;
   // transmit state
   logic [1:0] tx_count_reg, tx_count_next, tx_tries_reg;
   logic tx_ready_reg, tx_err_reg, tx_nak_reg, tx_stall_reg, tx_tog_reg;
   logic tx_dma_reg, tx_style_reg, tx_force_reg, tx_dir_reg;
   logic [7:0] tx_frames_reg;
   // engine and bus
   eng_e state_reg;
   logic cur_tx_reg, last_tx_reg, ack_reg;
   logic [31:0] rd_mux, wd;
   logic [15:0] rx_csr, tx_csr;
   // bus handshake: one wait cycle, then the access completes
   assign waitrequest = (read | write) & ~ack_reg;
   wire acc_wr = write & ~waitrequest;
   wire [31:0] bmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
   assign wd = (rd_mux & ~bmask) | (writedata & bmask);
   // write decode
   wire wr_rx_csr = acc_wr & (address == usb_ep_pkg::off_rx_csr);
   wire wr_tx_csr = acc_wr & (address == usb_ep_pkg::off_tx_csr);
   // buffer capacity and occupancy
   wire [1:0] rx_cap = rx_dbuf_reg ? 2'h2 : 2'h1;
   wire [1:0] tx_cap = tx_dbuf_reg ? 2'h2 : 2'h1;
   wire rx_full = rx_count_reg == rx_cap;
   wire tx_full = tx_count_reg == tx_cap;
   wire rx_ready = rx_count_reg != 2'h0;
   wire tx_occupied = tx_count_reg != 2'h0;
   // endpoint type decode
   wire rx_is_int = rx_type_reg[usb_ep_pkg::type_lsb +: 2] == usb_ep_pkg::tt_interrupt;
   wire tx_is_int = tx_type_reg[usb_ep_pkg::type_lsb +: 2] == usb_ep_pkg::tt_interrupt;
   // polling slot for interrupt type, immediate for bulk
   wire rx_slot = ~rx_is_int | (rx_interval_reg == 8'h00) | (rx_frames_reg >= rx_interval_reg);
   wire tx_slot = ~tx_is_int | (tx_interval_reg == 8'h00) | (tx_frames_reg >= tx_interval_reg);
   // pending work on each side
   wire rx_want = rx_req_reg & ~rx_nak_reg & ~rx_full & rx_slot;
   wire tx_want = tx_ready_reg & tx_occupied & ~tx_nak_reg & tx_slot;
   wire pick_tx = tx_want & (~rx_want | ~last_tx_reg);
   // answer classification
   wire done = (state_reg == st_wait) & resp_valid;
   wire rsp_rx = done & ~cur_tx_reg;
   wire rsp_tx = done & cur_tx_reg;
   wire is_data = resp.kind == usb_ep_pkg::resp_data;
   wire is_nak = resp.kind == usb_ep_pkg::resp_nak;
   wire is_stall = resp.kind == usb_ep_pkg::resp_stall;
   wire is_ack = (resp.kind == usb_ep_pkg::resp_ack) | (resp.kind == usb_ep_pkg::resp_nyet);
   wire rx_data_ok = rsp_rx & is_data & (resp.toggle_value == rx_tog_reg);
   wire rx_nak_in = rsp_rx & is_nak;
   wire rx_stall_in = rsp_rx & is_stall;
   wire rx_none = rsp_rx & ~is_data & ~is_nak & ~is_stall;
   wire rx_err_set = rx_none & (rx_tries_reg == usb_ep_pkg::last_try);
   wire rx_nak_set = rx_nak_in & ~rx_is_int & (rx_interval_reg != 8'h00)
                     & (rx_frames_reg >= rx_interval_reg);
   wire tx_ack_in = rsp_tx & is_ack;
   wire tx_nak_in = rsp_tx & is_nak;
   wire tx_stall_in = rsp_tx & is_stall;
   wire tx_none = rsp_tx & ~is_ack & ~is_nak & ~is_stall;
   wire tx_err_set = tx_none & (tx_tries_reg == usb_ep_pkg::last_try);
   wire tx_nak_set = tx_nak_in & ~tx_is_int & (tx_interval_reg != 8'h00)
                     & (tx_frames_reg >= tx_interval_reg);
   // software actions on the receive side
   wire rx_sw_clear_ready = wr_rx_csr & ~wd[usb_ep_pkg::rx_ready_bit] & rx_ready;
   wire rx_discard = wr_rx_csr & wd[usb_ep_pkg::rx_discard_bit] & rx_ready;
   wire rx_pop = rx_sw_clear_ready | rx_discard;
   wire auto_on = (auto_in_reg == usb_ep_pkg::auto_in_a) | (auto_in_reg == usb_ep_pkg::auto_in_b);
   wire rx_auto_req = rx_sw_clear_ready & auto_on & rx_dma_reg;
   wire rx_push = rx_data_ok & ~rx_full;
   // software actions on the transmit side
   wire tx_discard = wr_tx_csr & wd[usb_ep_pkg::tx_discard_bit] & tx_occupied;
   wire tx_pop = tx_ack_in | tx_discard;
   wire tx_push = tx_load_done & ~tx_full;
   // packet counts, one buffer per packet
   assign rx_count_next = rx_count_reg + {1'b0, rx_push} - {1'b0, rx_pop};
   assign tx_count_next = tx_count_reg + {1'b0, tx_push} - {1'b0, tx_pop};
   // readback composition
   assign rx_csr = {2'h0, rx_dma_reg, rx_nyet_reg, rx_style_reg, 1'b0, rx_tog_reg, 1'b0, 1'b0,
                    rx_stall_reg, rx_req_reg, 1'b0, rx_nak_reg, rx_err_reg, 1'b0, rx_ready};
   assign tx_csr = {2'h0, tx_dir_reg, tx_dma_reg, tx_force_reg, tx_style_reg, 1'b0, tx_tog_reg,
                    tx_nak_reg, 1'b0, tx_stall_reg, 1'b0, 1'b0, tx_err_reg, tx_occupied, tx_ready_reg};
   // read mux, unmapped addresses read as zero
   always_comb
   begin
      unique case (address)
         usb_ep_pkg::off_rx_csr: rd_mux = {16'h0000, rx_csr};
         usb_ep_pkg::off_rx_type: rd_mux = {24'h000000, rx_type_reg};
         usb_ep_pkg::off_rx_interval: rd_mux = {24'h000000, rx_interval_reg};
         usb_ep_pkg::off_rx_limit: rd_mux = {21'h000000, rx_limit_reg};
         usb_ep_pkg::off_rx_addr: rd_mux = {25'h0000000, rx_addr_reg};
         usb_ep_pkg::off_rx_sizing: rd_mux = {27'h0000000, rx_dbuf_reg, 4'h0};
         usb_ep_pkg::off_tx_csr: rd_mux = {16'h0000, tx_csr};
         usb_ep_pkg::off_tx_type: rd_mux = {24'h000000, tx_type_reg};
         usb_ep_pkg::off_tx_interval: rd_mux = {24'h000000, tx_interval_reg};
         usb_ep_pkg::off_tx_limit: rd_mux = {21'h000000, tx_limit_reg};
         usb_ep_pkg::off_tx_addr: rd_mux = {25'h0000000, tx_addr_reg};
         usb_ep_pkg::off_tx_sizing: rd_mux = {27'h0000000, tx_dbuf_reg, 4'h0};
         usb_ep_pkg::off_auto_in: rd_mux = {30'h00000000, auto_in_reg};
         default: rd_mux = 32'h00000000;
      endcase
   end
   // bus acknowledge and registered read data
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         ack_reg <= 1'b0;
         readdata <= 32'h00000000;
      end
      else
      begin
         ack_reg <= (read | write) & ~ack_reg;
         readdata <= rd_mux;
      end
   end
   // configuration registers
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rx_type_reg <= 8'h00;
         tx_type_reg <= 8'h00;
         rx_interval_reg <= 8'h00;
         tx_interval_reg <= 8'h00;
         rx_limit_reg <= 11'h000;
         tx_limit_reg <= 11'h000;
         rx_addr_reg <= 7'h00;
         tx_addr_reg <= 7'h00;
         rx_dbuf_reg <= 1'b0;
         tx_dbuf_reg <= 1'b0;
         auto_in_reg <= 2'h0;
      end
      else if (acc_wr)
      begin
         if (address == usb_ep_pkg::off_rx_type) rx_type_reg <= wd[7:0];
         if (address == usb_ep_pkg::off_tx_type) tx_type_reg <= wd[7:0];
         if (address == usb_ep_pkg::off_rx_interval) rx_interval_reg <= wd[7:0];
         if (address == usb_ep_pkg::off_tx_interval) tx_interval_reg <= wd[7:0];
         if (address == usb_ep_pkg::off_rx_limit) rx_limit_reg <= wd[10:0];
         if (address == usb_ep_pkg::off_tx_limit) tx_limit_reg <= wd[10:0];
         if (address == usb_ep_pkg::off_rx_addr) rx_addr_reg <= wd[6:0];
         if (address == usb_ep_pkg::off_tx_addr) tx_addr_reg <= wd[6:0];
         if (address == usb_ep_pkg::off_rx_sizing) rx_dbuf_reg <= wd[usb_ep_pkg::dbuf_bit];
         if (address == usb_ep_pkg::off_tx_sizing) tx_dbuf_reg <= wd[usb_ep_pkg::dbuf_bit];
         if (address == usb_ep_pkg::off_auto_in) auto_in_reg <= wd[1:0];
      end
   end
   // receive control bits; hardware set wins over software clear
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rx_count_reg <= 2'h0;
         rx_req_reg <= 1'b0;
         rx_err_reg <= 1'b0;
         rx_nak_reg <= 1'b0;
         rx_stall_reg <= 1'b0;
         rx_dma_reg <= 1'b0;
         rx_nyet_reg <= 1'b0;
         rx_style_reg <= 1'b0;
      end
      else
      begin
         rx_count_reg <= rx_count_next;
         if (rx_auto_req)
            rx_req_reg <= 1'b1;
         else if (rx_data_ok | rx_stall_in | rx_err_set)
            rx_req_reg <= 1'b0;
         else if (wr_rx_csr)
            rx_req_reg <= wd[usb_ep_pkg::rx_req_bit];
         rx_err_reg <= rx_err_set | (rx_err_reg & ~(wr_rx_csr & ~wd[usb_ep_pkg::rx_err_bit]));
         rx_nak_reg <= rx_nak_set | (rx_nak_reg & ~(wr_rx_csr & ~wd[usb_ep_pkg::rx_nak_bit]));
         rx_stall_reg <= rx_stall_in | (rx_stall_reg & ~(wr_rx_csr & ~wd[usb_ep_pkg::rx_stall_bit]));
         if (wr_rx_csr)
         begin
            rx_dma_reg <= wd[usb_ep_pkg::rx_dma_bit];
            rx_nyet_reg <= wd[usb_ep_pkg::rx_nyet_bit];
            rx_style_reg <= wd[usb_ep_pkg::rx_style_bit];
         end
      end
   end
   // receive data toggle
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         rx_tog_reg <= 1'b0;
      else if (wr_rx_csr & wd[usb_ep_pkg::rx_tog_reset_bit])
         rx_tog_reg <= 1'b0;
      else if (wr_rx_csr & wd[usb_ep_pkg::rx_tog_we_bit])
         rx_tog_reg <= wd[usb_ep_pkg::rx_tog_bit];
      else if (rx_push)
         rx_tog_reg <= ~rx_tog_reg;
   end
   // transmit control bits; hardware set wins over software clear
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         tx_count_reg <= 2'h0;
         tx_ready_reg <= 1'b0;
         tx_err_reg <= 1'b0;
         tx_nak_reg <= 1'b0;
         tx_stall_reg <= 1'b0;
         tx_dma_reg <= 1'b0;
         tx_style_reg <= 1'b0;
         tx_force_reg <= 1'b0;
         tx_dir_reg <= 1'b0;
      end
      else
      begin
         tx_count_reg <= tx_count_next;
         if (wr_tx_csr & wd[usb_ep_pkg::tx_ready_bit])
            tx_ready_reg <= 1'b1;
         else if ((tx_pop & (tx_count_next == 2'h0)) | tx_stall_in | tx_err_set)
            tx_ready_reg <= 1'b0;
         tx_err_reg <= tx_err_set | (tx_err_reg & ~(wr_tx_csr & ~wd[usb_ep_pkg::tx_err_bit]));
         tx_nak_reg <= tx_nak_set | (tx_nak_reg & ~(wr_tx_csr & ~wd[usb_ep_pkg::tx_nak_bit]));
         tx_stall_reg <= tx_stall_in | (tx_stall_reg & ~(wr_tx_csr & ~wd[usb_ep_pkg::tx_stall_bit]));
         if (wr_tx_csr)
         begin
            tx_dma_reg <= wd[usb_ep_pkg::tx_dma_bit];
            tx_style_reg <= wd[usb_ep_pkg::tx_style_bit];
            tx_force_reg <= wd[usb_ep_pkg::tx_force_bit];
            tx_dir_reg <= wd[usb_ep_pkg::tx_dir_bit];
         end
      end
   end
   // transmit data toggle; forced mode flips on every attempt answered
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         tx_tog_reg <= 1'b0;
      else if (wr_tx_csr & wd[usb_ep_pkg::tx_tog_reset_bit])
         tx_tog_reg <= 1'b0;
      else if (wr_tx_csr & wd[usb_ep_pkg::tx_tog_we_bit])
         tx_tog_reg <= wd[usb_ep_pkg::tx_tog_bit];
      else if (tx_ack_in | (tx_force_reg & rsp_tx))
         tx_tog_reg <= ~tx_tog_reg;
   end

   // consecutive silent attempts per side
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rx_tries_reg <= 2'h0;
         tx_tries_reg <= 2'h0;
      end
      else
      begin
         if (rsp_rx)
            rx_tries_reg <= (rx_none & ~rx_err_set) ? rx_tries_reg + 2'h1 : 2'h0;
         if (rsp_tx)
            tx_tries_reg <= (tx_none & ~tx_err_set) ? tx_tries_reg + 2'h1 : 2'h0;
      end
   end

   // frame counters: nak age for bulk, poll spacing for interrupt type
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rx_frames_reg <= 8'h00;
         tx_frames_reg <= 8'h00;
      end
      else
      begin
         if (~rx_req_reg | rx_data_ok | rx_stall_in | rx_err_set | rx_nak_set | (rx_nak_in & rx_is_int))
            rx_frames_reg <= 8'h00;
         else if (frame_tick & (rx_frames_reg != usb_ep_pkg::frames_max))
            rx_frames_reg <= rx_frames_reg + 8'h01;
         if (~tx_ready_reg | tx_ack_in | tx_stall_in | tx_err_set | tx_nak_set | (tx_nak_in & tx_is_int))
            tx_frames_reg <= 8'h00;
         else if (frame_tick & (tx_frames_reg != usb_ep_pkg::frames_max))
            tx_frames_reg <= tx_frames_reg + 8'h01;
      end
   end

   // transaction engine: pick a side, hand the token over, await the answer
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_reg <= st_idle;
         cur_tx_reg <= 1'b0;
         last_tx_reg <= 1'b0;
         token <= '0;
      end
      else
      begin
         unique case (state_reg)
            st_idle:
               if (rx_want | tx_want)
               begin
                  state_reg <= st_token;
                  cur_tx_reg <= pick_tx;
                  last_tx_reg <= pick_tx;
                  token.is_out <= pick_tx;
                  token.target_address <= pick_tx ? tx_addr_reg : rx_addr_reg;
                  token.remote_endpoint <= pick_tx ? tx_type_reg[3:0] : rx_type_reg[3:0];
                  token.speed <= pick_tx ? tx_type_reg[usb_ep_pkg::speed_lsb +: 2]
                                         : rx_type_reg[usb_ep_pkg::speed_lsb +: 2];
                  token.transfer_type <= pick_tx ? tx_type_reg[usb_ep_pkg::type_lsb +: 2]
                                                 : rx_type_reg[usb_ep_pkg::type_lsb +: 2];
                  token.toggle_value <= pick_tx ? tx_tog_reg : rx_tog_reg;
               end
            st_token:
               if (token_ready)
                  state_reg <= st_wait;
            st_wait:
               if (resp_valid)
                  state_reg <= st_idle;
         endcase
      end
   end
   assign token_valid = state_reg == st_token;

   // dma requests and endpoint events
   assign rx_dma_req = rx_dma_reg & rx_ready;
   assign tx_dma_req = tx_dma_reg & ~tx_full;
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rx_ep_event <= 1'b0;
         tx_ep_event <= 1'b0;
      end
      else
      begin
         rx_ep_event <= (rx_push & ~rx_dma_reg) | rx_stall_in | rx_err_set | rx_nak_set;
         tx_ep_event <= (tx_ack_in & ~(tx_dma_reg & tx_style_reg)) | tx_stall_in | tx_err_set | tx_nak_set;
      end
   end

endmodule : usb_host_bulk_interrupt_endpoint

/* usb_ep_asserts.sv */
`timescale 1ns/1ps
module usb_ep_asserts (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // register bus
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   // link side
   input wire logic token_valid,
   input wire logic token_ready,
   input wire usb_ep_pkg::token_s token,
   input wire logic resp_valid,
   // requests and events
   input wire logic rx_dma_req,
   input wire logic rx_ep_event,
   input wire logic tx_ep_event
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // bus answers and link ordering
   property p_wait_one; (read || write) && waitrequest |=> !waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("bus access not answered after one wait cycle");
   property p_wait_idle; !(read || write) |-> !waitrequest; endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("waitrequest high while idle");
   property p_tok_hold; token_valid && !token_ready |=> token_valid && $stable(token); endproperty
   a_tok_hold: assert property (p_tok_hold) else $error("token dropped or changed before taken");
   property p_one_out; token_valid && token_ready |=> !token_valid; endproperty
   a_one_out: assert property (p_one_out) else $error("second token while one outstanding");
   property p_gap; resp_valid |=> !token_valid; endproperty
   a_gap: assert property (p_gap) else $error("retry token right after answer");
   // events and dma requests
   property p_rx_dma; $rose(rx_dma_req) |-> !rx_ep_event; endproperty
   a_rx_dma: assert property (p_rx_dma) else $error("completion event with receive dma on");
   property p_rx_cause; $rose(rx_ep_event) |-> $past(resp_valid); endproperty
   a_rx_cause: assert property (p_rx_cause) else $error("receive event without an answer");
   property p_tx_cause; $rose(tx_ep_event) |-> $past(resp_valid); endproperty
   a_tx_cause: assert property (p_tx_cause) else $error("transmit event without an answer");
endmodule : usb_ep_asserts
bind usb_host_bulk_interrupt_endpoint usb_ep_asserts u_chk (.ref_clk(ref_clk), .reset(reset), .read(read),
   .write(write), .waitrequest(waitrequest), .token_valid(token_valid), .token_ready(token_ready), .token(token),
   .resp_valid(resp_valid), .rx_dma_req(rx_dma_req), .rx_ep_event(rx_ep_event), .tx_ep_event(tx_ep_event));

/* usb_peripheral_model.sv */
`timescale 1ns/1ps
module usb_peripheral_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // link from the host endpoint
   input wire logic token_valid,
   output logic token_ready,
   input wire usb_ep_pkg::token_s token,
   output logic resp_valid,
   output usb_ep_pkg::link_resp_s resp,
   // answer chosen by the bench
   input wire usb_ep_pkg::link_resp_s answer,
   input wire logic [3:0] answer_delay,
   // tokens seen
   output usb_ep_pkg::token_s last_token,
   output logic [7:0] token_count
);
   logic [3:0] wait_reg;
   logic busy_reg;
   // take one token, wait, answer once; idle answer lines toggle
   always_ff @(posedge ref_clk)
   begin
      token_ready <= !busy_reg && token_valid && !token_ready;
      resp_valid <= 1'b0;
      resp <= ~resp;
      if (reset)
      begin
         busy_reg <= 1'b0;
         resp <= '0;
         token_count <= 8'h00;
      end
      else if (token_valid && token_ready)
      begin
         busy_reg <= 1'b1;
         wait_reg <= answer_delay;
         last_token <= token;
         token_count <= token_count + 8'h01;
      end
      else if (busy_reg && wait_reg != 4'h0)
         wait_reg <= wait_reg - 4'h1;
      else if (busy_reg)
      begin
         busy_reg <= 1'b0;
         resp_valid <= 1'b1;
         resp <= answer;
      end
   end
endmodule : usb_peripheral_model

/* usb_host_bulk_interrupt_endpoint_test.sv */
`timescale 1ns/1ps
module usb_host_bulk_interrupt_endpoint_test;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [5:0] address = 6'h00;
   logic [3:0] byteenable = 4'hf;
   logic [31:0] writedata = 32'h0;
   logic frame_tick = 1'b0;
   logic tx_load_done = 1'b0;
   logic [3:0] answer_delay = 4'h0;
   logic [3:0] tick_cnt = 4'h0;
   logic [31:0] readdata;
   logic waitrequest, token_valid, token_ready, resp_valid, rx_dma_req, tx_dma_req, rx_ep_event, tx_ep_event;
   logic [3:0] watch;
   logic [7:0] token_count, base;
   usb_ep_pkg::token_s token, last_token;
   usb_ep_pkg::link_resp_s resp;
   usb_ep_pkg::link_resp_s answer = '0;
   int failures = 0;
   int cmp_count = 0;
   int rx_ev_n = 0;
   assign watch = {tx_dma_req, rx_dma_req, tx_ep_event, rx_ep_event};
   usb_host_bulk_interrupt_endpoint DUT (.*);
   usb_peripheral_model u_peer (.*);
   // clock, frame tick every 16 cycles, receive event count
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      tick_cnt <= tick_cnt + 4'h1;
      frame_tick <= (tick_cnt == 4'hf);
   end
   always @(negedge ref_clk) if (rx_ep_event === 1'b1) rx_ev_n++;
   task end_of_test;
      if (failures == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one avalon access, held until waitrequest is low at a rising edge
   task automatic bus(input logic r, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge ref_clk);
      address <= a;
      writedata <= d;
      read <= r;
      write <= !r;
      do begin @(posedge ref_clk); n++; end while (waitrequest !== 1'b0 && n < 50);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 50) failures++;
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b0, a, d, q);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [31:0] e, input string n);
      logic [31:0] q;
      bus(1'b1, a, 32'h0, q);
      chk(n, e, q);
   endtask : rd
   task automatic wait_hi(input int w);
      int n = 0;
      do begin @(negedge ref_clk); n++; end while (watch[w] !== 1'b1 && n < 400);
      chk("wait", 32'h1, {31'h0, n < 400});
   endtask : wait_hi
   task ans(input usb_ep_pkg::link_resp_e k, input logic t);
      answer <= '{k, t};
   endtask : ans
   // watchdog
   initial
   begin
      #60000;
      failures++;
      end_of_test();
   end
   // scenarios
   initial
   begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      rd(6'h00, 32'h0, "rx_csr");
      rd(6'h18, 32'h0, "tx_csr");
      rd(6'h3c, 32'h0, "unmapped");
      wr(6'h10, 32'h5);
      wr(6'h04, 32'h63);
      ans(usb_ep_pkg::resp_data, 1'b0);
      wr(6'h00, 32'h20);
      wait_hi(0);
      chk("in token", {16'h0, 1'b0, 7'h05, 4'h3, 2'h1, usb_ep_pkg::tt_bulk}, {16'h0, last_token[16:1]});
      rd(6'h00, 32'h201, "rx_csr");
      wr(6'h00, 32'h0);
      ans(usb_ep_pkg::resp_stall, 1'b0);
      wr(6'h00, 32'h20);
      wait_hi(0);
      rd(6'h00, 32'h240, "rx_csr");
      wr(6'h00, 32'h0);
      ans(usb_ep_pkg::resp_none, 1'b0);
      answer_delay <= 4'h9;
      base = token_count;
      wr(6'h00, 32'h20);
      wait_hi(0);
      rd(6'h00, 32'h204, "rx_csr");
      chk("tries", 32'h3, {24'h0, token_count - base});
      answer_delay <= 4'h0;
      wr(6'h00, 32'h80);
      rd(6'h00, 32'h0, "rx_csr");
      wr(6'h00, 32'h600);
      rd(6'h00, 32'h200, "rx_csr");
      wr(6'h08, 32'h2);
      ans(usb_ep_pkg::resp_nak, 1'b0);
      wr(6'h00, 32'h20);
      wait_hi(0);
      rd(6'h00, 32'h228, "rx_csr");
      wr(6'h00, 32'h208);
      wr(6'h00, 32'h200);
      base = token_count;
      repeat (40) @(negedge ref_clk);
      chk("abort", {24'h0, base}, {24'h0, token_count});
      wr(6'h08, 32'h0);
      wr(6'h30, 32'h1);
      ans(usb_ep_pkg::resp_data, 1'b1);
      base = rx_ev_n[7:0];
      wr(6'h00, 32'h2020);
      wait_hi(2);
      repeat (3) @(posedge ref_clk);
      chk("rx events", {24'h0, base}, rx_ev_n);
      ans(usb_ep_pkg::resp_data, 1'b0);
      base = token_count;
      wr(6'h00, 32'h2000);
      repeat (20) @(negedge ref_clk);
      chk("auto in", {24'h0, base + 8'h01}, {24'h0, token_count});
      wr(6'h30, 32'h0);
      wr(6'h00, 32'h0);
      wr(6'h28, 32'h9);
      wr(6'h1c, 32'ha4);
      ans(usb_ep_pkg::resp_ack, 1'b0);
      tx_load_done <= 1'b1;
      @(posedge ref_clk);
      tx_load_done <= 1'b0;
      rd(6'h18, 32'h2, "tx_csr");
      wr(6'h18, 32'h1);
      wait_hi(1);
      chk("out token", {16'h0, 1'b1, 7'h09, 4'h4, 2'h2, usb_ep_pkg::tt_bulk}, {16'h0, last_token[16:1]});
      rd(6'h18, 32'h100, "tx_csr");
      tx_load_done <= 1'b1;
      @(posedge ref_clk);
      tx_load_done <= 1'b0;
      wr(6'h18, 32'h108);
      rd(6'h18, 32'h100, "tx_csr");
      wr(6'h18, 32'h1000);
      wait_hi(3);
      end_of_test();
   end
endmodule : usb_host_bulk_interrupt_endpoint_test
